// ===== hdl/stom_regs.svh
// Timing constants for the torque-off input monitor
`ifndef STOM_REGS_SVH
`define STOM_REGS_SVH
`define STOM_CLK_HZ 10000000
`define STOM_RESP_MS 10
`define STOM_STATUS_MS 15
`define STOM_FILT_US 600
`define STOM_SKEW_MS 500
`define STOM_OFF_MS 500
// Filter length: longest test pulse plus one cycle so a 600 us pulse never passes
`define STOM_FILT_CYC ((`STOM_FILT_US * (`STOM_CLK_HZ / 1000000)) + 1)
// Skew and off-time limits: least times, rounded up (exact here)
`define STOM_SKEW_CYC (`STOM_SKEW_MS * (`STOM_CLK_HZ / 1000))
`define STOM_OFF_CYC (`STOM_OFF_MS * (`STOM_CLK_HZ / 1000))
// Latest reaction allowed, in cycles, rounded down
`define STOM_RESP_CYC (`STOM_RESP_MS * (`STOM_CLK_HZ / 1000))
`define STOM_STATUS_CYC (`STOM_STATUS_MS * (`STOM_CLK_HZ / 1000))
`endif

// ===== hdl/stom_pkg.sv
// Types for the torque-off input monitor
package stom_pkg;
  typedef enum logic [1:0] {
    STOM_RUN,
    STOM_OFF,
    STOM_HOLD
  } stom_state_e;
  typedef logic [22:0] stom_cnt_t;
endpackage

// ===== hdl/stom_monitor.sv
// Two-channel torque-off input monitor with test-pulse filter and restart lockout
`timescale 1ns/1ns
`default_nettype none
`include "stom_regs.svh"
// Behaviour
// - Block pulse pattern within 10 ms.
// - Status output changes within 15 ms.
// - Ignore low test pulses up to 600 us.
// - Re-enable only after 500 ms both off.
// - Internal error forces torque-off.
// - Status high only when both inputs low.
// - Fault when one channel off over 500 ms.
module stom_monitor
  import stom_pkg::*;
#(
  parameter int FILT_CYC = `STOM_FILT_CYC,
  parameter int SKEW_CYC = `STOM_SKEW_CYC,
  parameter int OFF_CYC = `STOM_OFF_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic channel_a_request, // Pin, high = run allowed
  input wire logic channel_b_request, // Pin, high = run allowed
  input wire logic internal_error, // Same-domain error from card logic
  input wire logic fault_confirm, // Pulse that clears the fault
  input wire logic [5:0] pulse_in, // Pulse pattern from control board
  output logic [5:0] pulse_out, // Pulse pattern to power unit
  output logic torque_off, // High while pulses are blocked
  output logic wiring_status_out, // High when both inputs read low
  output logic fault_single_channel // Sticky confirmable fault, cause 1
);
  // Latest allowed blocking reaction, in cycles of the real clock
  localparam int unsigned RESP_MAX = `STOM_RESP_CYC;
  // Synchroniser stages, two per channel
  logic [1:0] s1_q, s2_q;
  // Filtered levels and per-channel low counters
  logic [1:0] filt_q, filt_d;
  stom_cnt_t low_q [2];
  stom_cnt_t low_d [2];
  // Skew and off-time counters
  stom_cnt_t skew_q, skew_d, off_q, off_d;
  stom_state_e st_q, st_d;
  logic fault_q, fault_d, stat_q, stat_d, tq_q, tq_d;
  logic [5:0] pls_q, pls_d;
  logic any_off, both_off;
  // Checker helper: cycles a channel has read low while pulses still flow
  stom_cnt_t blk_q [2];
  stom_cnt_t blk_d [2];

  // Input synchroniser; only the second stage is read
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
    end else begin
      s1_q <= {channel_b_request, channel_a_request};
      s2_q <= s1_q;
    end
  end

  // Per-channel filter: a low must last past the test-pulse length to count
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      always_comb begin
        low_d[g] = low_q[g];
        filt_d[g] = filt_q[g];
        if (s2_q[g]) begin
          // High is taken at once; releases need no filtering for safety
          low_d[g] = '0;
          filt_d[g] = 1'b1;
        end else if (low_q[g] < stom_cnt_t'(FILT_CYC)) begin
          low_d[g] = low_q[g] + stom_cnt_t'(1);
        end else begin
          filt_d[g] = 1'b0;
        end
      end
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          low_q[g] <= '0;
          filt_q[g] <= 1'b0;
        end else begin
          low_q[g] <= low_d[g];
          filt_q[g] <= filt_d[g];
        end
      end
      // Reaction timer for the checker; a long window cannot be a delay range
      always_comb begin
        blk_d[g] = blk_q[g];
        if (s2_q[g] || tq_q) begin
          blk_d[g] = '0;
        end else if (blk_q[g] < stom_cnt_t'(RESP_MAX)) begin
          blk_d[g] = blk_q[g] + stom_cnt_t'(1);
        end
      end
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          blk_q[g] <= '0;
        end else begin
          blk_q[g] <= blk_d[g];
        end
      end
    end
  endgenerate

  assign any_off = ~filt_q[0] | ~filt_q[1];
  assign both_off = ~filt_q[0] & ~filt_q[1];

  // State, timers, fault and outputs: next values
  always_comb begin
    st_d = st_q;
    skew_d = skew_q;
    off_d = off_q;
    fault_d = fault_q;
    // Single-channel request timer; runs only while exactly one is off
    if (any_off && !both_off) begin
      if (skew_q < stom_cnt_t'(SKEW_CYC)) begin
        skew_d = skew_q + stom_cnt_t'(1);
      end else begin
        fault_d = 1'b1;
      end
    end else begin
      skew_d = '0;
    end
    // Set wins over confirm
    if (fault_confirm && !(any_off && !both_off && skew_q >= stom_cnt_t'(SKEW_CYC))) begin
      fault_d = 1'b0;
    end
    unique case (st_q)
      STOM_RUN: begin
        if (any_off || internal_error || fault_q) begin
          st_d = STOM_OFF;
        end
        off_d = '0;
      end
      STOM_OFF: begin
        // Both channels off together must last the minimum time
        if (both_off) begin
          if (off_q < stom_cnt_t'(OFF_CYC)) begin
            off_d = off_q + stom_cnt_t'(1);
          end
        end else begin
          off_d = '0;
        end
        if (off_q >= stom_cnt_t'(OFF_CYC)) begin
          st_d = STOM_HOLD;
        end
      end
      STOM_HOLD: begin
        // Wait for both channels released, no error and no fault
        if (!any_off && !internal_error && !fault_q) begin
          st_d = STOM_RUN;
        end
      end
    endcase
    if (internal_error) begin
      st_d = STOM_OFF;
      off_d = '0;
    end
    tq_d = (st_d != STOM_RUN);
    pls_d = tq_d ? 6'h00 : pulse_in;
    stat_d = ~s2_q[0] & ~s2_q[1];
  end

  // Register the state group
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= STOM_OFF;
      skew_q <= '0;
      off_q <= '0;
      fault_q <= 1'b0;
      tq_q <= 1'b1;
      pls_q <= 6'h00;
      stat_q <= 1'b0;
    end else begin
      st_q <= st_d;
      skew_q <= skew_d;
      off_q <= off_d;
      fault_q <= fault_d;
      tq_q <= tq_d;
      pls_q <= pls_d;
      stat_q <= stat_d;
    end
  end

  assign pulse_out = pls_q;
  assign torque_off = tq_q;
  assign wiring_status_out = stat_q;
  assign fault_single_channel = fault_q;

  // Checks
  property p_block;
    @(posedge clk_sys) disable iff (!resetn)
      (blk_q[0] < stom_cnt_t'(RESP_MAX)) && (blk_q[1] < stom_cnt_t'(RESP_MAX));
  endproperty
  a_block: assert property (p_block) else $error("pulses not blocked after request");
  property p_gate;
    @(posedge clk_sys) disable iff (!resetn)
      torque_off |-> pulse_out == 6'h00;
  endproperty
  a_gate: assert property (p_gate) else $error("pulses pass while torque is off");
  property p_status;
    @(posedge clk_sys) disable iff (!resetn)
      (!s2_q[0] && !s2_q[1]) |=> wiring_status_out;
  endproperty
  a_status: assert property (p_status) else $error("status not high with both low");
  property p_nor;
    @(posedge clk_sys) disable iff (!resetn)
      (s2_q[0] || s2_q[1]) |=> !wiring_status_out;
  endproperty
  a_nor: assert property (p_nor) else $error("status high with an input high");
  property p_filter;
    @(posedge clk_sys) disable iff (!resetn)
      (st_q == STOM_RUN && !internal_error && !fault_q && s2_q == 2'h3) ##1 !s2_q[0] |=> !torque_off [*3];
  endproperty
  a_filter: assert property (p_filter) else $error("short low pulse caused torque-off");
  property p_rel;
    @(posedge clk_sys) disable iff (!resetn)
      (st_q == STOM_OFF && off_q < stom_cnt_t'(OFF_CYC)) |=> torque_off;
  endproperty
  a_rel: assert property (p_rel) else $error("released before off time");
  property p_err;
    @(posedge clk_sys) disable iff (!resetn)
      internal_error |=> torque_off && pulse_out == 6'h00;
  endproperty
  a_err: assert property (p_err) else $error("internal error did not force off");
  property p_fault;
    @(posedge clk_sys) disable iff (!resetn)
      (any_off && !both_off && skew_q >= stom_cnt_t'(SKEW_CYC)) |=> fault_single_channel;
  endproperty
  a_fault: assert property (p_fault) else $error("single channel fault missing");
  property p_sync;
    @(posedge clk_sys) disable iff (!resetn)
      1'b1 |=> s2_q == $past(s1_q);
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser stage skipped");
  c_off: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(torque_off));
  c_run: cover property (@(posedge clk_sys) disable iff (!resetn) $fell(torque_off));
  c_fault: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(fault_single_channel));
endmodule
`default_nettype wire

// ===== tb/stom_partner.sv
// Safety switching device model driving both request lines
`timescale 1ns/1ns
`default_nettype none
module stom_partner (
  input wire logic off_a, // Torque-off request, channel A
  input wire logic off_b, // Torque-off request, channel B
  input wire logic tp_a, // Low-going test pulse on line A
  output logic channel_a_request, // High = run allowed
  output logic channel_b_request // High = run allowed
);
  // Caller sets edge skew; each line follows only its own inputs, on release as well
  assign channel_a_request = ~(off_a | tp_a);
  assign channel_b_request = ~off_b;
endmodule
`default_nettype wire

// ===== tb/stom_monitor_tb_top.sv
// Self-checking bench for the torque-off input monitor
`timescale 1ns/1ns
`default_nettype none
module stom_monitor_tb_top;
  // Short counts keep the run brief
  localparam int FC = 10;
  localparam int SC = 50;
  localparam int OC = 50;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic off_a;
  logic off_b;
  logic tp_a;
  logic internal_error;
  logic fault_confirm;
  logic [5:0] pulse_in;
  logic [5:0] pulse_out, pin_q;
  logic chan_a, chan_b, torque_off, wiring_status_out, fault_single_channel;
  logic [1:0] prev_q = 2'h1; // Last seen {fault, torque_off}
  logic [1:0] exp_q[$]; // Notes of expected {fault, torque_off}
  int num_errors = 0;
  int num_checks = 0;
  always #50 clk_sys = ~clk_sys;
  stom_partner part_u (.off_a(off_a), .off_b(off_b), .tp_a(tp_a),
    .channel_a_request(chan_a), .channel_b_request(chan_b));
  stom_monitor #(.FILT_CYC(FC), .SKEW_CYC(SC), .OFF_CYC(OC)) dut_u (.clk_sys(clk_sys), .resetn(resetn),
    .channel_a_request(chan_a), .channel_b_request(chan_b), .internal_error(internal_error),
    .fault_confirm(fault_confirm), .pulse_in(pulse_in), .pulse_out(pulse_out), .torque_off(torque_off),
    .wiring_status_out(wiring_status_out), .fault_single_channel(fault_single_channel));
  task automatic check(input logic [5:0] seen, input logic [5:0] want);
    num_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic complete_run();
    if (num_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Step n edges, then land just after the last one
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Bounded wait for all noted changes; running out ends the run
  task automatic wait_q(input int n);
    for (int i = 0; i < n && exp_q.size() > 0; i++) @(posedge clk_sys);
    #1;
    if (exp_q.size() > 0) begin
      check(6'h3f, 6'h00);
      complete_run();
    end
  endtask
  // Fresh random pattern every cycle so pass-through faults show
  always @(posedge clk_sys) begin
    #1;
    pulse_in = 6'($urandom);
  end
  // Mid-cycle watcher: any change must match the oldest note
  always @(negedge clk_sys) begin
    if (resetn) begin
      if ({fault_single_channel, torque_off} !== prev_q) begin
        if (exp_q.size() > 0) begin
          check({4'h0, fault_single_channel, torque_off}, {4'h0, exp_q.pop_front()});
        end else begin
          check({4'h0, fault_single_channel, torque_off}, {4'h0, prev_q});
        end
      end
      if (torque_off === 1'b1) begin
        check(pulse_out, 6'h00);
      end else if (prev_q[0] === 1'b0) begin
        check(pulse_out, pin_q);
      end
    end
    prev_q = {fault_single_channel, torque_off};
    pin_q = pulse_in;
  end
  initial begin
    off_a = 1'b1;
    off_b = 1'b1;
    tp_a = 1'b0;
    internal_error = 1'b0;
    fault_confirm = 1'b0;
    pulse_in = 6'h00;
    void'($urandom(97));
    cyc(5);
    check({5'h00, torque_off}, 6'h01);
    resetn = 1'b1;
    // Both lines off for the full lockout, then released together
    cyc(OC + FC + 10);
    exp_q.push_back(2'h0);
    off_a = 1'b0;
    off_b = 1'b0;
    wait_q(FC + 10);
    // Test pulse at the longest ignored length
    tp_a = 1'b1;
    cyc(FC);
    tp_a = 1'b0;
    cyc(20);
    check({5'h00, torque_off}, 6'h00);
    // One channel alone: blocked, status low, then fault
    exp_q.push_back(2'h1);
    off_a = 1'b1;
    wait_q(FC + 6);
    check({5'h00, wiring_status_out}, 6'h00);
    exp_q.push_back(2'h3);
    wait_q(SC + 10);
    off_b = 1'b1;
    cyc(3);
    check({5'h00, wiring_status_out}, 6'h01);
    // Let channel B pass its filter, else the fault set still beats the confirm
    cyc(FC + 5);
    exp_q.push_back(2'h1);
    fault_confirm = 1'b1;
    cyc(1);
    fault_confirm = 1'b0;
    wait_q(5);
    // Release before the lockout has run must be refused
    cyc(5);
    off_a = 1'b0;
    off_b = 1'b0;
    cyc(FC + 20);
    check({5'h00, torque_off}, 6'h01);
    off_a = 1'b1;
    off_b = 1'b1;
    cyc(OC + FC + 10);
    exp_q.push_back(2'h0);
    off_a = 1'b0;
    off_b = 1'b0;
    wait_q(FC + 10);
    // Internal error stops a running drive
    exp_q.push_back(2'h1);
    internal_error = 1'b1;
    wait_q(3);
    complete_run();
  end
endmodule
`default_nettype wire
